// [src/vr_cmd_params.svh]
/*
 * constants of the voltage command block: rail addresses, protocol codes,
 * code ranges, command codes and packet layout.
 * assumes inclusion from the package and the design modules by bare name.
 */
// Overview of operation
// - rail switching uses only working point select of states 1 and 2.
// - the master programs working point states 0 to 4 in every rail domain.
// - a fast set goes to exactly one rail address, never a group address.
// - performance state voltage changes use the slow set command.
// - the decay set only lowers the voltage; the regulator lets it fall.
// - decay is sent only on entry to the deepest package idle state.
// - every packet carries a 4-bit regulator address field.
// - bus 0 holds main 00/0A, always-on 01/09, io rails 02 and 03/04.
// - bus 1 holds only the memory supply rail at 00 with protocol 07.
// - main rail code 6F is 1.60 V, 10 mV steps, up to 8C.
// - commanded main rail codes stay within 6F to 86.
// - always-on code 8D is 0.950 V, 5 mV steps, up to 97.
// - both io rails get code 83, the memory supply rail code AB.
`ifndef VR_CMD_PARAMS_SVH
`define VR_CMD_PARAMS_SVH

`define ADDR_W 4
`define CODE_W 8
`define CMD_W 5
`define FRAME_W 25
`define RAIL_CNT 5
`define WP_PROG_CNT 5
`define WP_SEL_LO 3'h1
`define WP_SEL_HI 3'h2
`define WP_REG_BASE 8'h3A

`define ADDR_MAIN 4'h0
`define ADDR_AON 4'h1
`define ADDR_IO_HV 4'h2
`define ADDR_IO_ANALOG 4'h3
`define ADDR_MEM 4'h0
`define ADDR_GROUP_LO 4'hE

`define PROTO_MAIN 8'h0A
`define PROTO_AON 8'h09
`define PROTO_IO 8'h04
`define PROTO_MEM 8'h07

`define MAIN_CODE_MIN 8'h6F
`define MAIN_CODE_MAX 8'h86
`define AON_CODE_MIN 8'h8D
`define AON_CODE_MAX 8'h97
`define IO_CODE 8'h83
`define MEM_CODE 8'hAB

`define CMD_FAST 5'h01
`define CMD_SLOW 5'h02
`define CMD_DECAY 5'h03
`define CMD_WP_SELECT 5'h04
`define CMD_REG_WRITE 5'h05

`endif

// [src/vr_cmd_pkg.sv]
/*
 * types of the voltage command block.
 * assumes the constants header is on the include path.
 */
`include "vr_cmd_params.svh"

package vr_cmd_pkg;

    typedef enum logic [2:0] {
        RAIL_MAIN = 3'h0,
        RAIL_AON = 3'h1,
        RAIL_IO_HV = 3'h2,
        RAIL_IO_ANALOG = 3'h3,
        RAIL_MEM = 3'h4
    } rail_t;

    typedef enum logic [1:0] {
        REQ_PSTATE = 2'h0,
        REQ_FAST = 2'h1,
        REQ_IDLE_DECAY = 2'h2,
        REQ_WP_SELECT = 2'h3
    } req_kind_t;

    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_IDLE = 3'h2,
        ST_SEND = 3'h4
    } ctrl_state_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'h1,
        SER_SHIFT = 2'h2
    } ser_state_t;

    typedef struct packed {
        logic bus;
        logic [`ADDR_W-1:0] addr;
        logic [7:0] proto;
        logic [`CODE_W-1:0] code_min;
        logic [`CODE_W-1:0] code_max;
    } rail_info_t;

endpackage

// [src/vr_link_if.sv]
/*
 * packet hand-off between the command controller and the link serializer.
 * assumes both ends share clock_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vr_cmd_params.svh"

interface vr_link_if;
    logic frame_valid;
    logic frame_ready;
    logic frame_bus;
    logic [`FRAME_W-1:0] frame;

    modport ctrl (output frame_valid, output frame_bus, output frame, input frame_ready);
    modport ser (input frame_valid, input frame_bus, input frame, output frame_ready);
endinterface

`default_nettype wire

// [src/vr_link_serializer.sv]
/*
 * shifts one packet out, msb first, on the selected bus data line (open drain).
 * assumes link_clk_i is a free pin sampled by clock_i; bits change on its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vr_cmd_params.svh"

module vr_link_serializer
    import vr_cmd_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic link_clk_i,
    vr_link_if.ser link,
    output logic [1:0] data_o,
    output logic [1:0] data_oe_o
);

    typedef struct packed {
        logic [2:0] clk_sync;
        ser_state_t state;
        logic bus;
        logic [`FRAME_W-1:0] shift;
        logic [4:0] left;
        logic ready;
        logic [1:0] oe;
    } ser_s_t;

    ser_s_t cur;
    ser_s_t next_s;
    logic fall;

    always_comb begin
        next_s = cur;
        next_s.clk_sync = {cur.clk_sync[1:0], link_clk_i};
        // only the second and third stages feed the edge detector
        fall = cur.clk_sync[2] & ~cur.clk_sync[1];
        case (cur.state)
            SER_IDLE: begin
                if (link.frame_valid && cur.ready) begin
                    next_s.state = SER_SHIFT;
                    next_s.bus = link.frame_bus;
                    next_s.shift = link.frame;
                    next_s.left = 5'(`FRAME_W);
                    next_s.ready = 1'b0;
                end
            end
            SER_SHIFT: begin
                if (fall) begin
                    if (cur.left == 5'h00) begin
                        next_s.state = SER_IDLE;
                        next_s.ready = 1'b1;
                        next_s.oe = 2'h0;
                    end else begin
                        // zero pulls the line low, one releases it
                        next_s.oe = 2'h0;
                        next_s.oe[cur.bus] = ~cur.shift[`FRAME_W-1];
                        next_s.shift = {cur.shift[`FRAME_W-2:0], 1'b0};
                        next_s.left = cur.left - 5'h01;
                    end
                end
            end
            default: begin
                next_s.state = SER_IDLE;
                next_s.ready = 1'b1;
                next_s.oe = 2'h0;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur <= '{clk_sync: 3'h0, state: SER_IDLE, bus: 1'b0, shift: '0, left: 5'h00,
                     ready: 1'b1, oe: 2'h0};
        end else begin
            cur <= next_s;
        end
    end

    assign link.frame_ready = cur.ready;
    assign data_oe_o = cur.oe;
    assign data_o = 2'h0;

endmodule // vr_link_serializer

`default_nettype wire

// [src/vr_serial_voltage_commands.sv]
/*
 * processor side voltage command controller: boots the working point tables,
 * then checks, clamps and addresses requests and hands packets to the serializer.
 * assumes requests come from logic on clock_i; link_clk_i is a free running pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vr_cmd_params.svh"

module vr_serial_voltage_commands
    import vr_cmd_pkg::*;
#(
    parameter int CODE_W = `CODE_W
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire logic [1:0] req_kind_i,
    input wire logic [2:0] req_rail_i,
    input wire logic [7:0] req_code_i,
    input wire logic [2:0] req_wp_i,
    input wire logic deep_idle_entry_i,
    input wire logic link_clk_i,
    output logic req_ready_o,
    output logic accept_o,
    output logic reject_o,
    output logic [7:0] sent_code_o,
    output logic [7:0] sent_protocol_o,
    output logic [1:0] data_o,
    output logic [1:0] data_oe_o
);

    if (CODE_W != 8) begin : g_width_check
        $error("vr_serial_voltage_commands: payload must be one byte");
    end

    // per rail bus, address, protocol and allowed code window
    function automatic rail_info_t rail_info(input logic [2:0] r);
        rail_info_t i;
        i = '{bus: 1'b0, addr: `ADDR_MAIN, proto: `PROTO_MAIN,
              code_min: `MAIN_CODE_MIN, code_max: `MAIN_CODE_MAX};
        case (r)
            RAIL_MAIN: begin
                i = '{bus: 1'b0, addr: `ADDR_MAIN, proto: `PROTO_MAIN,
                      code_min: `MAIN_CODE_MIN, code_max: `MAIN_CODE_MAX};
            end
            RAIL_AON: begin
                i = '{bus: 1'b0, addr: `ADDR_AON, proto: `PROTO_AON,
                      code_min: `AON_CODE_MIN, code_max: `AON_CODE_MAX};
            end
            RAIL_IO_HV: begin
                i = '{bus: 1'b0, addr: `ADDR_IO_HV, proto: `PROTO_IO,
                      code_min: `IO_CODE, code_max: `IO_CODE};
            end
            RAIL_IO_ANALOG: begin
                i = '{bus: 1'b0, addr: `ADDR_IO_ANALOG, proto: `PROTO_IO,
                      code_min: `IO_CODE, code_max: `IO_CODE};
            end
            RAIL_MEM: begin
                i = '{bus: 1'b1, addr: `ADDR_MEM, proto: `PROTO_MEM,
                      code_min: `MEM_CODE, code_max: `MEM_CODE};
            end
            default: begin
                i = '{bus: 1'b0, addr: `ADDR_GROUP_LO, proto: 8'h00,
                      code_min: 8'h00, code_max: 8'h00};
            end
        endcase
        return i;
    endfunction

    function automatic logic [7:0] clamp_code(input logic [7:0] c, input rail_info_t i);
        logic [7:0] r;
        r = c;
        if (c < i.code_min) begin
            r = i.code_min;
        end else if (c > i.code_max) begin
            r = i.code_max;
        end
        return r;
    endfunction

    typedef struct packed {
        ctrl_state_t state;
        logic [2:0] init_rail;
        logic [2:0] init_wp;
        logic [`RAIL_CNT-1:0][7:0] last_code;
        logic frame_valid;
        logic frame_bus;
        logic [`FRAME_W-1:0] frame;
        logic req_ready;
        logic accept;
        logic reject;
        logic [7:0] sent_code;
        logic [7:0] sent_proto;
    } ctrl_s_t;

    localparam logic [`RAIL_CNT-1:0][7:0] BOOT_CODES =
        {`MEM_CODE, `IO_CODE, `IO_CODE, `AON_CODE_MIN, `MAIN_CODE_MIN};

    ctrl_s_t cur;
    ctrl_s_t next_s;
    rail_info_t req_info;
    rail_info_t init_info;
    logic [7:0] req_clamped;
    logic [`CMD_W-1:0] req_cmd;
    logic req_ok;

    vr_link_if link ();

    always_comb begin
        req_info = rail_info(req_rail_i);
        init_info = rail_info(cur.init_rail);
        req_clamped = clamp_code(req_code_i, req_info);
        req_cmd = `CMD_SLOW;
        req_ok = (req_rail_i < 3'(`RAIL_CNT));
        case (req_kind_i)
            REQ_PSTATE: begin
                req_cmd = `CMD_SLOW;
            end
            REQ_FAST: begin
                req_cmd = `CMD_FAST;
                req_ok = req_ok && (req_info.addr < `ADDR_GROUP_LO);
            end
            REQ_IDLE_DECAY: begin
                req_cmd = `CMD_DECAY;
                req_ok = req_ok && deep_idle_entry_i &&
                         (req_clamped < cur.last_code[req_rail_i]);
            end
            REQ_WP_SELECT: begin
                req_cmd = `CMD_WP_SELECT;
                req_ok = req_ok && (req_wp_i == `WP_SEL_LO || req_wp_i == `WP_SEL_HI);
            end
            default: begin
                req_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_s = cur;
        next_s.accept = 1'b0;
        next_s.reject = 1'b0;
        case (cur.state)
            ST_INIT: begin
                // program states 0 to 4 per rail
                if (!cur.frame_valid) begin
                    next_s.frame_valid = 1'b1;
                    next_s.frame_bus = init_info.bus;
                    next_s.frame = {init_info.addr, `CMD_REG_WRITE,
                                    `WP_REG_BASE + 8'(cur.init_wp),
                                    BOOT_CODES[cur.init_rail]};
                end else if (link.frame_ready) begin
                    next_s.frame_valid = 1'b0;
                    if (cur.init_wp == 3'(`WP_PROG_CNT - 1)) begin
                        next_s.init_wp = 3'h0;
                        if (cur.init_rail == 3'(`RAIL_CNT - 1)) begin
                            next_s.state = ST_IDLE;
                            next_s.req_ready = 1'b1;
                        end else begin
                            next_s.init_rail = cur.init_rail + 3'h1;
                        end
                    end else begin
                        next_s.init_wp = cur.init_wp + 3'h1;
                    end
                end
            end
            ST_IDLE: begin
                if (req_valid_i && cur.req_ready) begin
                    if (req_ok) begin
                        next_s.state = ST_SEND;
                        next_s.req_ready = 1'b0;
                        next_s.accept = 1'b1;
                        next_s.frame_valid = 1'b1;
                        next_s.frame_bus = req_info.bus;
                        next_s.frame = {req_info.addr, req_cmd, 5'h00, req_wp_i,
                                        (req_kind_i == REQ_WP_SELECT) ? 8'h00 : req_clamped};
                        next_s.sent_proto = req_info.proto;
                        if (req_kind_i != REQ_WP_SELECT) begin
                            next_s.sent_code = req_clamped;
                            next_s.last_code[req_rail_i] = req_clamped;
                        end
                    end else begin
                        next_s.reject = 1'b1;
                    end
                end
            end
            ST_SEND: begin
                if (link.frame_ready) begin
                    next_s.frame_valid = 1'b0;
                    next_s.state = ST_IDLE;
                    next_s.req_ready = 1'b1;
                end
            end
            default: begin
                next_s.state = ST_IDLE;
                next_s.frame_valid = 1'b0;
                next_s.req_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur <= '{state: ST_INIT, init_rail: 3'h0, init_wp: 3'h0, last_code: BOOT_CODES,
                     frame_valid: 1'b0, frame_bus: 1'b0, frame: '0, req_ready: 1'b0,
                     accept: 1'b0, reject: 1'b0, sent_code: 8'h00, sent_proto: 8'h00};
        end else begin
            cur <= next_s;
        end
    end

    assign link.frame_valid = cur.frame_valid;
    assign link.frame_bus = cur.frame_bus;
    assign link.frame = cur.frame;

    vr_link_serializer u_serializer (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .link_clk_i(link_clk_i),
        .link(link.ser),
        .data_o(data_o),
        .data_oe_o(data_oe_o)
    );

    assign req_ready_o = cur.req_ready;
    assign accept_o = cur.accept;
    assign reject_o = cur.reject;
    assign sent_code_o = cur.sent_code;
    assign sent_protocol_o = cur.sent_proto;

endmodule // vr_serial_voltage_commands

`default_nettype wire

// [tb/vr_cmd_sva.sv]
/* checker of the voltage command block: answers, refusals, clamped codes.
   assumes binding to the top module, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "vr_cmd_params.svh"
module vr_cmd_sva (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire logic [1:0] req_kind_i,
    input wire logic [2:0] req_rail_i,
    input wire logic [2:0] req_wp_i,
    input wire logic deep_idle_entry_i,
    input wire logic req_ready_o,
    input wire logic accept_o,
    input wire logic reject_o,
    input wire logic [7:0] sent_code_o,
    input wire logic [7:0] sent_protocol_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    logic take;
    logic setk;
    logic set_kind_q;
    assign take = req_valid_i && req_ready_o;
    // set kind (not working point select) of the request input one edge ago, sampled on every edge
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            set_kind_q <= 1'b0;
        end else begin
            set_kind_q <= (req_kind_i != 2'h3);
        end
    end
    assign setk = accept_o && set_kind_q;
    property p_answer; take |=> accept_o ^ reject_o; endproperty
    property p_cause; (accept_o || reject_o) |-> $past(take); endproperty
    property p_rail; take && req_rail_i > 3'h4 |=> reject_o; endproperty
    property p_wp; take && req_kind_i == 2'h3 && req_wp_i != 3'h1 && req_wp_i != 3'h2 |=> reject_o; endproperty
    property p_decay; take && req_kind_i == 2'h2 && !deep_idle_entry_i |=> reject_o; endproperty
    property p_main; setk && $past(req_rail_i) == 3'h0 |=> sent_code_o inside {[`MAIN_CODE_MIN:`MAIN_CODE_MAX]};
    endproperty
    property p_aon; setk && $past(req_rail_i) == 3'h1 |=> sent_code_o inside {[`AON_CODE_MIN:`AON_CODE_MAX]};
    endproperty
    property p_io; setk && $past(req_rail_i) inside {3'h2, 3'h3} |=> sent_code_o == `IO_CODE; endproperty
    property p_mem; setk && $past(req_rail_i) == 3'h4 |=> sent_code_o == `MEM_CODE && sent_protocol_o == `PROTO_MEM;
    endproperty
    property p_proto; accept_o && $past(req_rail_i) == 3'h0 |=> sent_protocol_o == `PROTO_MAIN; endproperty
    a_answer: assert property (p_answer) else $error("no single answer");
    a_cause: assert property (p_cause) else $error("answer without request");
    a_rail: assert property (p_rail) else $error("bad rail taken");
    a_wp: assert property (p_wp) else $error("bad working point taken");
    a_decay: assert property (p_decay) else $error("decay outside deep idle");
    a_main: assert property (p_main) else $error("main code out of range");
    a_aon: assert property (p_aon) else $error("always-on code out of range");
    a_io: assert property (p_io) else $error("io code wrong");
    a_mem: assert property (p_mem) else $error("memory code wrong");
    a_proto: assert property (p_proto) else $error("main protocol wrong");
    c_accept: cover property (take ##1 accept_o);
    c_reject: cover property (take ##1 reject_o);
    c_decay: cover property (take && req_kind_i == 2'h2 ##1 accept_o);
endmodule // vr_cmd_sva
bind vr_serial_voltage_commands vr_cmd_sva u_sva (.clock_i(clock_i), .resetn_i(resetn_i),
    .req_valid_i(req_valid_i), .req_kind_i(req_kind_i), .req_rail_i(req_rail_i), .req_wp_i(req_wp_i),
    .deep_idle_entry_i(deep_idle_entry_i), .req_ready_o(req_ready_o), .accept_o(accept_o),
    .reject_o(reject_o), .sent_code_o(sent_code_o), .sent_protocol_o(sent_protocol_o));
`default_nettype wire

// [tb/vr_regulator_model.sv]
/* regulator controllers on both buses: capture packets, keep codes and tables.
   assumes pulled-up data lines and a free running link clock. */
`timescale 1ns/1ps
`default_nettype none
`include "vr_cmd_params.svh"
module vr_regulator_model (
    input wire logic resetn_i,
    input wire logic [1:0] line_i,
    output logic link_clk_o
);
    logic [25:0] got[$];
    logic [7:0] code [32] = '{default: 8'hFF};
    logic [7:0] wp [32][8];
    logic [7:0] prog [32] = '{default: 8'h00};
    int decay_up = 0;
    int cnt [2] = '{0, 0};
    logic [24:0] sh [2];
    initial begin
        link_clk_o = 1'b1;
        forever #80 link_clk_o = ~link_clk_o;
    end
    task automatic take_frame(input logic b, input logic [24:0] f);
        logic [4:0] a;
        logic [7:0] n;
        a = {b, f[24:21]};
        n = f[15:8] - `WP_REG_BASE;
        got.push_back({b, f});
        case (f[20:16])
            `CMD_REG_WRITE: begin
                wp[a][n[2:0]] = f[7:0];
                prog[a][n[2:0]] = 1'b1;
            end
            `CMD_WP_SELECT: if (prog[a][f[10:8]]) code[a] = wp[a][f[10:8]];
            `CMD_DECAY: begin
                if (f[7:0] >= code[a]) decay_up++;
                code[a] = f[7:0];
            end
            default: code[a] = f[7:0];
        endcase
    endtask
    always @(posedge link_clk_o) begin
        for (int b = 0; b < 2; b++) begin
            if (!resetn_i) begin
                cnt[b] = 0;
            end else if (cnt[b] != 0 || !line_i[b]) begin
                sh[b] = {sh[b][23:0], line_i[b]};
                cnt[b]++;
                if (cnt[b] == 25) begin
                    cnt[b] = 0;
                    take_frame(b[0], sh[b]);
                end
            end
        end
    end
endmodule // vr_regulator_model
`default_nettype wire

// [tb/tb_top.sv]
/* self-checking bench of the voltage command block.
   assumes the regulator model on the link and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "vr_cmd_params.svh"
module tb_top;
    logic clock_i, resetn_i, req_valid_i, deep_idle_entry_i;
    logic [1:0] req_kind_i;
    logic [2:0] req_rail_i, req_wp_i;
    logic [7:0] req_code_i, sent_code_o, sent_protocol_o;
    logic req_ready_o, accept_o, reject_o;
    logic [1:0] data_o, data_oe_o, line;
    wire logic link_clk;
    int bad_count = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'd71449;
    logic [7:0] last [5];
    logic [7:0] exp_code = 8'h00;
    logic [7:0] exp_proto = 8'h00;
    logic [26:0] exp_q[$];
    logic [7:0] lo_t [5] = '{`MAIN_CODE_MIN, `AON_CODE_MIN, `IO_CODE, `IO_CODE, `MEM_CODE};
    logic [7:0] hi_t [5] = '{`MAIN_CODE_MAX, `AON_CODE_MAX, `IO_CODE, `IO_CODE, `MEM_CODE};
    logic [7:0] pr_t [5] = '{`PROTO_MAIN, `PROTO_AON, `PROTO_IO, `PROTO_IO, `PROTO_MEM};
    logic [3:0] ad_t [5] = '{`ADDR_MAIN, `ADDR_AON, `ADDR_IO_HV, `ADDR_IO_ANALOG, `ADDR_MEM};
    assign line = ~data_oe_o | data_o;
    vr_serial_voltage_commands u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
        .req_kind_i(req_kind_i), .req_rail_i(req_rail_i), .req_code_i(req_code_i), .req_wp_i(req_wp_i),
        .deep_idle_entry_i(deep_idle_entry_i), .link_clk_i(link_clk), .req_ready_o(req_ready_o),
        .accept_o(accept_o), .reject_o(reject_o), .sent_code_o(sent_code_o),
        .sent_protocol_o(sent_protocol_o), .data_o(data_o), .data_oe_o(data_oe_o));
    vr_regulator_model u_vr (.resetn_i(resetn_i), .line_i(line), .link_clk_o(link_clk));
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready_o !== 1'b1) begin
            @(posedge clock_i);
            #1;
            n++;
            if (n > 20000) begin
                check("ready wait", 0, 1);
                final_report();
            end
        end
    endtask
    task automatic do_req(input logic [1:0] k, input logic [2:0] r, input logic [7:0] c, input logic [2:0] w,
        input logic idle);
        logic acc;
        logic [7:0] cl;
        logic [4:0] cmd;
        cl = 8'h00;
        acc = 1'b0;
        cmd = (k == 2'h0) ? `CMD_SLOW : (k == 2'h1) ? `CMD_FAST : (k == 2'h2) ? `CMD_DECAY : `CMD_WP_SELECT;
        if (r <= 3'h4) begin
            cl = (c < lo_t[r]) ? lo_t[r] : (c > hi_t[r]) ? hi_t[r] : c;
            acc = (k == 2'h3) ? (w == 3'h1 || w == 3'h2) : (k != 2'h2 || (idle && cl < last[r]));
        end
        wait_ready();
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_kind_i <= k;
        req_rail_i <= r;
        req_code_i <= c;
        req_wp_i <= w;
        deep_idle_entry_i <= idle;
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        #1;
        check("accept", accept_o, acc);
        check("reject", reject_o, !acc);
        if (acc) begin
            if (k != 2'h3) last[r] = cl;
            if (k != 2'h3) exp_code = cl;
            exp_proto = pr_t[r];
            exp_q.push_back({k == 2'h3, r == 3'h4, ad_t[r], cmd, (k == 2'h3) ? {5'h00, w} : 8'h00,
                (k == 2'h3) ? 8'h00 : cl});
        end
        @(posedge clock_i);
        #1;
        check("sent code", sent_code_o, exp_code);
        check("sent protocol", sent_protocol_o, exp_proto);
        if (!acc) check("ready after refusal", req_ready_o, 1);
    endtask
    task automatic drain(input string name);
        logic [26:0] e;
        logic [25:0] g;
        int n;
        logic hit;
        n = 0;
        while (u_vr.got.size() < exp_q.size() && n < 40000) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 40000) begin
            check("frame wait", 0, 1);
            final_report();
        end
        while (u_vr.got.size() > 0) begin
            g = u_vr.got.pop_front();
            hit = 1'b0;
            for (int i = 0; i < exp_q.size() && !hit; i++) begin
                e = exp_q[i];
                hit = e[26] ? (e[25:0] === g) : ({e[25:16], e[7:0]} === {g[25:16], g[7:0]});
                if (hit) exp_q.delete(i);
            end
            check("frame match", hit, 1);
        end
        check("frames missing", exp_q.size(), 0);
        $display("test %s done", name);
    endtask
    initial begin
        resetn_i = 1'b0;
        req_valid_i = 1'b0;
        req_kind_i = 2'h0;
        req_rail_i = 3'h0;
        req_code_i = 8'h00;
        req_wp_i = 3'h0;
        deep_idle_entry_i = 1'b0;
        for (int i = 0; i < 5; i++) begin
            last[i] = lo_t[i];
            for (int j = 0; j < 5; j++) begin
                exp_q.push_back({1'b1, i == 4, ad_t[i], `CMD_REG_WRITE, `WP_REG_BASE + 8'(j), lo_t[i]});
            end
        end
        repeat (16) @(posedge clock_i);
        resetn_i <= 1'b1;
        wait_ready();
        drain("boot");
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            do_req(2'h0, 3'(i % 5), seed[7:0], 3'h0, 1'b0);
        end
        foreach (lo_t[i]) do_req(2'h1, 3'(i), 8'h00, 3'h0, 1'b0);
        foreach (hi_t[i]) do_req(2'h1, 3'(i), 8'hFF, 3'h0, 1'b0);
        do_req(2'h1, 3'h0, 8'h6E, 3'h0, 1'b0);
        do_req(2'h1, 3'h0, 8'h87, 3'h0, 1'b0);
        drain("set commands");
        do_req(2'h0, 3'h0, 8'h80, 3'h0, 1'b0);
        do_req(2'h2, 3'h0, 8'h70, 3'h0, 1'b0);
        do_req(2'h2, 3'h0, 8'h90, 3'h0, 1'b1);
        do_req(2'h2, 3'h0, 8'h75, 3'h0, 1'b1);
        do_req(2'h2, 3'h0, 8'h75, 3'h0, 1'b1);
        do_req(2'h2, 3'h4, 8'h00, 3'h0, 1'b1);
        drain("decay");
        check("decay upward", u_vr.decay_up, 0);
        check("main code", u_vr.code[0], 8'h75);
        do_req(2'h0, 3'h1, 8'h97, 3'h0, 1'b0);
        for (int w = 0; w < 8; w++) do_req(2'h3, 3'h1, 8'h00, 3'(w), 1'b0);
        drain("working point");
        check("aon code", u_vr.code[1], `AON_CODE_MIN);
        for (int r = 5; r < 8; r++) begin
            for (int k = 0; k < 4; k++) do_req(2'(k), 3'(r), 8'h80, 3'h1, 1'b1);
        end
        $display("test bad rails done");
        final_report();
    end
endmodule // tb_top
`default_nettype wire
